// File: core/sdms_switcher.sv
// dual-mode control switcher with apb register access
// assumes pins arrive asynchronously; motion loops read the outputs
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`include "sdms_regs.svh"
`default_nettype none
module sdms_switcher
    import sdms_pkg::*;
#(
    parameter int DBNC_W = 16
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // selection pins from the host
    input wire logic spd_sel_in,
    input wire logic mode_sw_in,
    // position reached feedback from the position loop
    input wire logic pos_reached_in,
    // mode outputs
    output logic servo_run,
    output logic [2:0] active_src,
    output logic cmd_accept,
    output logic decel_zero,
    output logic ramp_dec_only,
    output logic cfg_err
);

// ****************************************************************
// pair table
// ****************************************************************
function automatic sdms_pair_t pair_map(input logic [4:0] code);
    sdms_pair_t p;
    p = '{valid: 1'b1, use_spd: 1'b0, on_src: SDMS_SRC_BUS,
          off_src: SDMS_SRC_BUS};
    case (code)
        `SDMS_P_ISPD_PPOS: p = '{1'b1, 1'b1, SDMS_SRC_ISPD, SDMS_SRC_PPOS};
        `SDMS_P_ISPD_ITRQ: p = '{1'b1, 1'b1, SDMS_SRC_ISPD, SDMS_SRC_ITRQ};
        `SDMS_P_ISPD_ASPD: p = '{1'b1, 1'b1, SDMS_SRC_ISPD, SDMS_SRC_ASPD};
        `SDMS_P_ISPD_ATRQ: p = '{1'b1, 1'b1, SDMS_SRC_ISPD, SDMS_SRC_ATRQ};
        `SDMS_P_ISPD_IPOS: p = '{1'b1, 1'b1, SDMS_SRC_ISPD, SDMS_SRC_IPOS};
        `SDMS_P_ITRQ_PPOS: p = '{1'b1, 1'b0, SDMS_SRC_PPOS, SDMS_SRC_ITRQ};
        `SDMS_P_ASPD_PPOS: p = '{1'b1, 1'b0, SDMS_SRC_PPOS, SDMS_SRC_ASPD};
        `SDMS_P_ATRQ_PPOS: p = '{1'b1, 1'b0, SDMS_SRC_PPOS, SDMS_SRC_ATRQ};
        `SDMS_P_PPOS_IPOS: p = '{1'b1, 1'b0, SDMS_SRC_IPOS, SDMS_SRC_PPOS};
        `SDMS_P_ASPD_ITRQ: p = '{1'b1, 1'b0, SDMS_SRC_ITRQ, SDMS_SRC_ASPD};
        `SDMS_P_ATRQ_ITRQ: p = '{1'b1, 1'b0, SDMS_SRC_ITRQ, SDMS_SRC_ATRQ};
        `SDMS_P_ITRQ_IPOS: p = '{1'b1, 1'b0, SDMS_SRC_IPOS, SDMS_SRC_ITRQ};
        `SDMS_P_ASPD_ATRQ: p = '{1'b1, 1'b0, SDMS_SRC_ATRQ, SDMS_SRC_ASPD};
        `SDMS_P_ASPD_IPOS: p = '{1'b1, 1'b0, SDMS_SRC_IPOS, SDMS_SRC_ASPD};
        `SDMS_P_ATRQ_IPOS: p = '{1'b1, 1'b0, SDMS_SRC_IPOS, SDMS_SRC_ATRQ};
        `SDMS_P_BUS: p = '{1'b1, 1'b0, SDMS_SRC_BUS, SDMS_SRC_BUS};
        `SDMS_P_PLC: p = '{1'b1, 1'b0, SDMS_SRC_PLC, SDMS_SRC_PLC};
        default: p.valid = 1'b0;
    endcase
    return p;
endfunction

function automatic logic is_pos(input sdms_src_t s);
    return (s == SDMS_SRC_PPOS) || (s == SDMS_SRC_IPOS);
endfunction
function automatic logic is_spd(input sdms_src_t s);
    return (s == SDMS_SRC_ISPD) || (s == SDMS_SRC_ASPD);
endfunction
function automatic logic is_trq(input sdms_src_t s);
    return (s == SDMS_SRC_ITRQ) || (s == SDMS_SRC_ATRQ);
endfunction

// ****************************************************************
// register file and apb slave
// ****************************************************************
logic [4:0] ctrl_pair_ff, nxt_ctrl_pair;
logic ctrl_en_ff, nxt_ctrl_en;
logic [DBNC_W-1:0] dbnc_lim_ff, nxt_dbnc_lim;
logic [31:0] prdata_ff, nxt_prdata;
logic pready_ff, nxt_pready;
logic pslverr_ff, nxt_pslverr;
logic [31:0] stat_word;
logic addr_ok;
logic wr_done;

sdms_state_t state_ff, nxt_state;
sdms_src_t src_ff, nxt_src;
sdms_src_t tgt_ff, nxt_tgt;
logic [4:0] pair_ff, nxt_pair;
logic accept_ff, nxt_accept;
logic decel_ff, nxt_decel;
logic deconly_ff, nxt_deconly;
logic cfgerr_ff, nxt_cfgerr;
logic run_ff, nxt_run;
logic [1:0] db_ff;
logic [2:0] sync1_ff, sync2_ff;

always_comb
begin
    addr_ok = (paddr == `SDMS_CTRL_OFS) || (paddr == `SDMS_STAT_OFS) ||
              (paddr == `SDMS_DBNC_OFS);
    wr_done = psel && penable && pready_ff && pwrite;
    stat_word = {11'h0, sync2_ff, db_ff, 4'h0, cfgerr_ff, deconly_ff,
                 decel_ff, accept_ff, 2'h0, state_ff, 1'b0, src_ff};
    nxt_ctrl_pair = ctrl_pair_ff;
    nxt_ctrl_en = ctrl_en_ff;
    nxt_dbnc_lim = dbnc_lim_ff;
    if (wr_done && paddr == `SDMS_CTRL_OFS)
    begin
        nxt_ctrl_pair = pwdata[`SDMS_PAIR_MSB:`SDMS_PAIR_LSB];
        nxt_ctrl_en = pwdata[`SDMS_EN_BIT];
    end
    if (wr_done && paddr == `SDMS_DBNC_OFS)
        nxt_dbnc_lim = pwdata[DBNC_W-1:0];
    // answer one cycle after setup
    nxt_pready = psel && !penable;
    nxt_pslverr = psel && !penable && !addr_ok;
    nxt_prdata = 32'h0;
    if (psel && !penable && !pwrite)
        case (paddr)
            `SDMS_CTRL_OFS: nxt_prdata = {23'h0, ctrl_en_ff, 3'h0,
                                          ctrl_pair_ff};
            `SDMS_STAT_OFS: nxt_prdata = stat_word;
            `SDMS_DBNC_OFS: nxt_prdata = 32'(dbnc_lim_ff);
            default: nxt_prdata = 32'h0;
        endcase
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctrl_pair_ff <= `SDMS_PAIR_RST;
        ctrl_en_ff <= 1'b0;
        dbnc_lim_ff <= DBNC_W'(`SDMS_DBNC_RST);
        prdata_ff <= 32'h0;
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
    end
    else
    begin
        ctrl_pair_ff <= nxt_ctrl_pair;
        ctrl_en_ff <= nxt_ctrl_en;
        dbnc_lim_ff <= nxt_dbnc_lim;
        prdata_ff <= nxt_prdata;
        pready_ff <= nxt_pready;
        pslverr_ff <= nxt_pslverr;
    end
end

// ****************************************************************
// pin synchronisers and debounce
// ****************************************************************
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sync1_ff <= 3'h0;
        sync2_ff <= 3'h0;
    end
    else
    begin
        sync1_ff <= {pos_reached_in, mode_sw_in, spd_sel_in};
        sync2_ff <= sync1_ff;
    end
end

genvar gi;
generate
    for (gi = 0; gi < 2; gi++)
    begin : g_dbnc
        logic [DBNC_W-1:0] cnt_ff, nxt_cnt;
        logic db_bit_ff, nxt_db_bit;
        // level must hold for the limit before it is taken
        always_comb
        begin
            nxt_cnt = '0;
            nxt_db_bit = db_bit_ff;
            if (sync2_ff[gi] != db_bit_ff && cnt_ff >= dbnc_lim_ff)
                nxt_db_bit = sync2_ff[gi];
            else if (sync2_ff[gi] != db_bit_ff)
                nxt_cnt = cnt_ff + DBNC_W'(1);
        end
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                cnt_ff <= '0;
                db_bit_ff <= 1'b0;
            end
            else
            begin
                cnt_ff <= nxt_cnt;
                db_bit_ff <= nxt_db_bit;
            end
        end
        assign db_ff[gi] = db_bit_ff;
    end
endgenerate

// ****************************************************************
// mode arbitration
// ****************************************************************
sdms_pair_t pmap;
sdms_src_t des;
logic reached;

always_comb
begin
    pmap = pair_map(pair_ff);
    reached = sync2_ff[2];
    des = (pmap.use_spd ? db_ff[0] : db_ff[1]) ? pmap.on_src : pmap.off_src;
    nxt_state = state_ff;
    nxt_src = src_ff;
    nxt_tgt = tgt_ff;
    nxt_pair = pair_ff;
    nxt_accept = accept_ff;
    nxt_decel = decel_ff;
    nxt_deconly = deconly_ff;
    nxt_cfgerr = cfgerr_ff;
    nxt_run = run_ff;
    case (state_ff)
        SDMS_ST_IDLE:
        begin
            // pair is only taken in idle
            nxt_pair = ctrl_pair_ff;
            nxt_cfgerr = !pmap.valid;
            nxt_accept = 1'b0;
            nxt_decel = 1'b0;
            nxt_deconly = 1'b0;
            nxt_run = 1'b0;
            if (ctrl_en_ff && pmap.valid && pair_ff == ctrl_pair_ff)
            begin
                nxt_state = SDMS_ST_RUN;
                nxt_src = des;
                nxt_accept = is_pos(des);
                nxt_run = 1'b1;
            end
        end
        SDMS_ST_RUN:
        begin
            if (!ctrl_en_ff)
            begin
                nxt_state = SDMS_ST_IDLE;
                nxt_run = 1'b0;
                nxt_accept = 1'b0;
            end
            else if (des != src_ff && is_pos(des))
            begin
                // stop first, block commands until reached
                nxt_state = SDMS_ST_STOP;
                nxt_tgt = des;
                nxt_accept = 1'b0;
                nxt_decel = !is_pos(src_ff);
                nxt_deconly = 1'b0;
            end
            else if (des != src_ff)
            begin
                // immediate switch; speed to torque on decel ramp
                nxt_src = des;
                nxt_accept = 1'b0;
                nxt_decel = 1'b0;
                nxt_deconly = is_trq(des) && is_spd(src_ff);
            end
        end
        SDMS_ST_STOP:
        begin
            if (!ctrl_en_ff)
            begin
                nxt_state = SDMS_ST_IDLE;
                nxt_run = 1'b0;
                nxt_decel = 1'b0;
            end
            else if (des != tgt_ff && !is_pos(des))
            begin
                nxt_state = SDMS_ST_RUN;
                nxt_src = des;
                nxt_decel = 1'b0;
                nxt_deconly = is_trq(des) && is_spd(src_ff);
            end
            else if (des != tgt_ff)
                nxt_tgt = des;
            else if (reached)
            begin
                nxt_state = SDMS_ST_RUN;
                nxt_src = tgt_ff;
                nxt_accept = 1'b1;
                nxt_decel = 1'b0;
            end
        end
        default:
        begin
            nxt_state = SDMS_ST_IDLE;
            nxt_run = 1'b0;
            nxt_accept = 1'b0;
        end
    endcase
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_ff <= SDMS_ST_IDLE;
        src_ff <= SDMS_SRC_ISPD;
        tgt_ff <= SDMS_SRC_ISPD;
        pair_ff <= `SDMS_PAIR_RST;
        accept_ff <= 1'b0;
        decel_ff <= 1'b0;
        deconly_ff <= 1'b0;
        cfgerr_ff <= 1'b0;
        run_ff <= 1'b0;
    end
    else
    begin
        state_ff <= nxt_state;
        src_ff <= nxt_src;
        tgt_ff <= nxt_tgt;
        pair_ff <= nxt_pair;
        accept_ff <= nxt_accept;
        decel_ff <= nxt_decel;
        deconly_ff <= nxt_deconly;
        cfgerr_ff <= nxt_cfgerr;
        run_ff <= nxt_run;
    end
end

assign prdata = prdata_ff;
assign pready = pready_ff;
assign pslverr = pslverr_ff;
assign servo_run = run_ff;
assign active_src = src_ff;
assign cmd_accept = accept_ff;
assign decel_zero = decel_ff;
assign ramp_dec_only = deconly_ff;
assign cfg_err = cfgerr_ff;

// ****************************************************************
// checks
// ****************************************************************
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

logic run_st;
assign run_st = (state_ff == SDMS_ST_RUN) && ctrl_en_ff;

sequence s_spd_to_pos;
    run_st && is_spd(src_ff) && is_pos(des);
endsequence
sequence s_stopping;
    state_ff == SDMS_ST_STOP && decel_ff && !accept_ff;
endsequence

chk_spd_stop_first: assert property (
    s_spd_to_pos |=> s_stopping)
    else $error("speed to position did not stop first");
chk_stop_blocks_cmd: assert property (
    state_ff == SDMS_ST_STOP |-> !accept_ff && src_ff != tgt_ff)
    else $error("commands accepted while stopping");
chk_reach_release: assert property (
    state_ff == SDMS_ST_STOP && ctrl_en_ff && des == tgt_ff && reached
    |=> state_ff == SDMS_ST_RUN && accept_ff && src_ff == $past(tgt_ff))
    else $error("reach did not release the position source");
chk_wait_reach: assert property (
    state_ff == SDMS_ST_STOP && ctrl_en_ff && des == tgt_ff && !reached
    |=> state_ff == SDMS_ST_STOP)
    else $error("left stop without reach");
chk_pulse_to_spd: assert property (
    run_st && pair_ff == `SDMS_P_ISPD_PPOS && src_ff == SDMS_SRC_PPOS
    && db_ff[0] |=> src_ff == SDMS_SRC_ISPD && !decel_ff)
    else $error("pulse to speed not immediate");
chk_pulse_to_aspd: assert property (
    run_st && pair_ff == `SDMS_P_ASPD_PPOS && src_ff == SDMS_SRC_PPOS
    && !db_ff[1] |=> src_ff == SDMS_SRC_ASPD && state_ff == SDMS_ST_RUN)
    else $error("pulse to analog speed not immediate");
chk_spd_spd_ramp: assert property (
    run_st && pair_ff == `SDMS_P_ISPD_ASPD
    |=> state_ff != SDMS_ST_STOP && !decel_ff)
    else $error("speed pair stopped");
chk_spd_trq_dec: assert property (
    run_st && pair_ff == `SDMS_P_ISPD_ITRQ && src_ff == SDMS_SRC_ISPD
    && !db_ff[0] |=> src_ff == SDMS_SRC_ITRQ && deconly_ff)
    else $error("speed to torque not on decel ramp");
chk_pos_pos_hold: assert property (
    run_st && pair_ff == `SDMS_P_PPOS_IPOS && src_ff == SDMS_SRC_PPOS
    && db_ff[1] |=> state_ff == SDMS_ST_STOP && !decel_ff && !accept_ff)
    else $error("position pair switched without reach");
chk_disable_idle: assert property (
    !ctrl_en_ff && state_ff != SDMS_ST_IDLE
    |=> state_ff == SDMS_ST_IDLE ##1 !servo_run)
    else $error("disable did not return to idle");

endmodule
`default_nettype wire

// File: core/sdms_regs.svh
// constants for the dual-mode control switcher: offsets, fields, resets
// assumes a 250 MHz pclk and an apb master with 32-bit data
//
// Contract
// - codes 6..10 pair internal speed with pulse, torque, analog, position
// - codes 11..16 pair torque, analog speed, pulse and internal position
// - codes 17..20 more pairs; 21 bus control; 22 built-in plc control
// - code 6: speed select high runs speed, low runs pulse position
// - speed to pulse: decelerate to zero, pulses blocked until reached
// - pulse to internal speed: switch at once, ramp with acc/dec
// - code 12: mode switch high runs pulse position, low analog speed
// - analog speed to pulse: decelerate, block pulses until reached
// - pulse to analog speed: switch at once and ramp
// - code 19: switch high internal position, stop first; low back at once
// - code 10: speed select low stops then position; high speed at once
// - torque plus pulse: switch high stops torque, blocks pulses
// - pulse back to torque: switch at once, ramp with acc/dec
// - torque plus internal position: stop before position, torque at once
// - code 14: new position source accepted only while reached
// - code 8: speed to speed ramps directly, never stops
// - internal speed with torque: torque uses decel ramp only
// - analog speed with torque: switch high torque on decel ramp
// - code 16: torque to torque ramps with acc/dec
`ifndef SDMS_REGS_SVH
`define SDMS_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SDMS_CTRL_OFS 8'h00
`define SDMS_STAT_OFS 8'h04
`define SDMS_DBNC_OFS 8'h08

// ****************************************************************
// fields and resets
// ****************************************************************
`define SDMS_PAIR_LSB 0
`define SDMS_PAIR_MSB 4
`define SDMS_EN_BIT 8
`define SDMS_PAIR_RST 5'h06
`define SDMS_CLK_PERIOD_NS 4
`define SDMS_DBNC_TIME_NS 64
`define SDMS_DBNC_RST \
    16'(`SDMS_DBNC_TIME_NS / `SDMS_CLK_PERIOD_NS)

// ****************************************************************
// control mode pair codes
// ****************************************************************
`define SDMS_P_ISPD_PPOS 5'h06
`define SDMS_P_ISPD_ITRQ 5'h07
`define SDMS_P_ISPD_ASPD 5'h08
`define SDMS_P_ISPD_ATRQ 5'h09
`define SDMS_P_ISPD_IPOS 5'h0a
`define SDMS_P_ITRQ_PPOS 5'h0b
`define SDMS_P_ASPD_PPOS 5'h0c
`define SDMS_P_ATRQ_PPOS 5'h0d
`define SDMS_P_PPOS_IPOS 5'h0e
`define SDMS_P_ASPD_ITRQ 5'h0f
`define SDMS_P_ATRQ_ITRQ 5'h10
`define SDMS_P_ITRQ_IPOS 5'h11
`define SDMS_P_ASPD_ATRQ 5'h12
`define SDMS_P_ASPD_IPOS 5'h13
`define SDMS_P_ATRQ_IPOS 5'h14
`define SDMS_P_BUS 5'h15
`define SDMS_P_PLC 5'h16

`endif

// File: core/sdms_pkg.sv
// types for the dual-mode control switcher
// assumes sdms_regs.svh supplies the numeric constants
`default_nettype none
package sdms_pkg;
    typedef enum logic [2:0] {
        SDMS_SRC_ISPD = 3'h0,
        SDMS_SRC_ASPD = 3'h1,
        SDMS_SRC_ITRQ = 3'h2,
        SDMS_SRC_ATRQ = 3'h3,
        SDMS_SRC_PPOS = 3'h4,
        SDMS_SRC_IPOS = 3'h5,
        SDMS_SRC_BUS = 3'h6,
        SDMS_SRC_PLC = 3'h7
    } sdms_src_t;

    // idle -> run -> stop along the usual path
    typedef enum logic [1:0] {
        SDMS_ST_IDLE = 2'b00,
        SDMS_ST_RUN = 2'b01,
        SDMS_ST_STOP = 2'b11
    } sdms_state_t;

    typedef struct packed {
        logic valid;
        logic use_spd;
        sdms_src_t on_src;
        sdms_src_t off_src;
    } sdms_pair_t;
endpackage
`default_nettype wire

// File: verification/sdms_host_model.sv
// host controller model: drives the selection pins and position reached
// assumes the bench asks for pin levels; each level is held at least HOLD+1 cycles
`default_nettype none
module sdms_host_model
#(
    parameter int HOLD = 6
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels asked for by the bench
    input wire logic want_spd,
    input wire logic want_mode,
    input wire logic want_reach,
    // pins toward the switcher
    output logic spd_sel_pin,
    output logic mode_sw_pin,
    output logic reached_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    int hold_ff;

    // ****************************************************************
    // pin driver
    // ****************************************************************
    // a new level waits until the previous one has stood HOLD+1 cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_ff <= 0;
            spd_sel_pin <= 1'b0;
            mode_sw_pin <= 1'b0;
            reached_pin <= 1'b0;
        end
        else if (hold_ff < HOLD)
            hold_ff <= hold_ff + 1;
        else if ({want_spd, want_mode, want_reach} !=
                 {spd_sel_pin, mode_sw_pin, reached_pin})
        begin
            spd_sel_pin <= want_spd;
            mode_sw_pin <= want_mode;
            reached_pin <= want_reach;
            hold_ff <= 0;
        end
    end
endmodule
`default_nettype wire

// File: verification/tb_sdms_switcher.sv
// self-checking bench for the dual-mode control switcher
// assumes sdms_host_model drives the pins; apb master lives here
`include "sdms_regs.svh"
`default_nettype none
module tb_sdms_switcher;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, spd_sel_in, mode_sw_in, pos_reached_in;
    logic servo_run, cmd_accept, decel_zero, ramp_dec_only, cfg_err;
    logic [2:0] active_src;
    logic want_spd = 1'b0;
    logic want_mode = 1'b0;
    logic want_reach = 1'b0;
    logic [31:0] rnd = 32'ha06a;
    logic [31:0] rd;
    logic err;
    logic [2:0] prev;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    always #2 pclk = ~pclk;

    sdms_switcher sdms_switcher_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .spd_sel_in(spd_sel_in),
        .mode_sw_in(mode_sw_in), .pos_reached_in(pos_reached_in),
        .servo_run(servo_run), .active_src(active_src),
        .cmd_accept(cmd_accept), .decel_zero(decel_zero),
        .ramp_dec_only(ramp_dec_only), .cfg_err(cfg_err));

    sdms_host_model sdms_host_model_i (.pclk(pclk), .presetn(presetn),
        .want_spd(want_spd), .want_mode(want_mode),
        .want_reach(want_reach), .spd_sel_pin(spd_sel_in),
        .mode_sw_pin(mode_sw_in), .reached_pin(pos_reached_in));

    // ****************************************************************
    // expectations
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // source for a pair code with its selection pin high or low
    function automatic logic [2:0] src_of(input logic [4:0] c,
                                          input logic l);
        case (c)
            5'h06: return l ? 3'h0 : 3'h4;
            5'h07: return l ? 3'h0 : 3'h2;
            5'h08: return l ? 3'h0 : 3'h1;
            5'h09: return l ? 3'h0 : 3'h3;
            5'h0a: return l ? 3'h0 : 3'h5;
            5'h0b: return l ? 3'h4 : 3'h2;
            5'h0c: return l ? 3'h4 : 3'h1;
            5'h0d: return l ? 3'h4 : 3'h3;
            5'h0e: return l ? 3'h5 : 3'h4;
            5'h0f: return l ? 3'h2 : 3'h1;
            5'h10: return l ? 3'h2 : 3'h3;
            5'h11: return l ? 3'h5 : 3'h2;
            5'h12: return l ? 3'h3 : 3'h1;
            5'h13: return l ? 3'h5 : 3'h1;
            5'h14: return l ? 3'h5 : 3'h3;
            5'h15: return 3'h6;
            default: return 3'h7;
        endcase
    endfunction

    function automatic logic is_pos(input logic [2:0] s);
        return s == 3'h4 || s == 3'h5;
    endfunction

    // ****************************************************************
    // drivers and checks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        check("pready_wait", 32'(i), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pins(input logic l, input logic use_spd,
                        input logic reach);
        want_spd <= use_spd & l;
        want_mode <= !use_spd & l;
        want_reach <= reach;
        repeat (24) @(posedge pclk);
    endtask

    // flip the selection pin; reached held low first, then raised
    task automatic go(input logic [4:0] c, input logic l);
        logic [2:0] n;
        n = src_of(c, l);
        pins(l, c <= 5'h0a, 1'b0);
        if (is_pos(n) && prev != n)
        begin
            check("accept_wait", 32'(cmd_accept), 32'h0);
            check("decel", 32'(decel_zero), 32'(!is_pos(prev)));
            if (!is_pos(prev))
            begin
                check("src_wait", 32'(active_src), 32'(prev));
                apb(1'b0, `SDMS_STAT_OFS, 32'h0);
                check("state", 32'(rd[5:4]), 32'h3);
                check("pins", 32'(rd[20:16]),
                      32'(c <= 5'h0a ? {2'h0, l, 1'b0, l}
                                     : {1'b0, l, 1'b0, l, 1'b0}));
            end
        end
        else
            check("src_now", 32'(active_src), 32'(n));
        pins(l, c <= 5'h0a, 1'b1);
        check("src", 32'(active_src), 32'(n));
        check("accept", 32'(cmd_accept), 32'(is_pos(n)));
        check("decel_done", 32'(decel_zero), 32'h0);
        if (prev != n)
            check("dec_only", 32'(ramp_dec_only),
                  32'(prev <= 3'h1 && (n == 3'h2 || n == 3'h3)));
        prev = n;
    endtask

    task automatic run_pair(input logic [4:0] c);
        apb(1'b1, `SDMS_CTRL_OFS, {23'h0, 1'b0, 3'h0, c});
        pins(1'b0, c <= 5'h0a, 1'b0);
        apb(1'b1, `SDMS_CTRL_OFS, {23'h0, 1'b1, 3'h0, c});
        repeat (24) @(posedge pclk);
        prev = src_of(c, 1'b0);
        check("run", 32'(servo_run), 32'h1);
        check("src_en", 32'(active_src), 32'(prev));
        check("cfg_ok", 32'(cfg_err), 32'h0);
        if (c < 5'h15)
        begin
            check("accept_en", 32'(cmd_accept), 32'(is_pos(prev)));
            go(c, 1'b1);
            go(c, 1'b0);
        end
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    initial
    begin
        static logic [4:0] bad [3] = '{5'h05, 5'h17, 5'h1f};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SDMS_CTRL_OFS, 32'h0);
        check("ctrl_rst", rd, 32'(`SDMS_PAIR_RST));
        apb(1'b0, `SDMS_DBNC_OFS, 32'h0);
        check("dbnc_rst", rd, 32'(`SDMS_DBNC_RST));
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped_rd", {rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h0c, 32'h5a5a);
        check("unmapped_wr", 32'(err), 32'h1);
        apb(1'b1, `SDMS_DBNC_OFS, 32'h2);
        apb(1'b0, `SDMS_DBNC_OFS, 32'h0);
        check("dbnc", {rd[31:1], err}, 32'h2);
        pins(1'b1, 1'b1, 1'b1);
        pins(1'b1, 1'b0, 1'b1);
        check("idle_run", 32'(servo_run), 32'h0);
        for (int c = 6; c <= 22; c++)
            run_pair(5'(c));
        foreach (bad[i])
        begin
            apb(1'b1, `SDMS_CTRL_OFS, {23'h0, 1'b0, 3'h0, bad[i]});
            apb(1'b1, `SDMS_CTRL_OFS, {23'h0, 1'b1, 3'h0, bad[i]});
            repeat (8) @(posedge pclk);
            check("cfg_err", 32'(cfg_err), 32'h1);
        end
        repeat (10)
        begin
            rnd = lfsr(rnd);
            run_pair(5'(6 + rnd % 17));
        end
        give_verdict();
    end
endmodule
`default_nettype wire
